// ---- src/smrc_pkg.sv ----
// ==========================================================================
package smrc_pkg;

  // ========================================================================
  // Register map (byte addresses on the AHB-Lite bus).
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CAUSE_ADDR = 8'h04;
  localparam logic [7:0] MON_CTRL_ADDR = 8'h08;
  localparam logic [7:0] SWRST_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h10;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h14;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h18;

  // ========================================================================
  // Field positions and reset values.
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int FLAGS_LSB = 2;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0] STACK_PTR_RESET = 8'h07;
  localparam int WDT_DIVIDE = 12;

  // Interrupt event bit positions.
  localparam int EV_STOP = 0;
  localparam int EV_IDLE = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_MCD = 3;

  // ========================================================================
  // Timing: clock 8 ns, release delay 0.3 ms, detector timeout 100 us.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int POR_DELAY_NS = 300000;
  localparam int POR_DELAY_CYC = POR_DELAY_NS * 1000 / CLK_PERIOD_PS;
  localparam int MCD_TIMEOUT_NS = 100000;
  localparam int MCD_TIMEOUT_CYC = MCD_TIMEOUT_NS * 1000 / CLK_PERIOD_PS;

  // Sequencer states.
  typedef enum logic [2:0] {
    SMRC_POR_HOLD, SMRC_POR_WAIT, SMRC_RESET, SMRC_RUN, SMRC_IDLE,
    SMRC_STOP
  } smrc_state_t;

endpackage

// ---- src/smrc_top.sv ----
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// ==========================================================================
// Stop/idle mode and reset sequencer with an AHB-Lite register slave.
module smrc_top #(
  parameter int POR_DELAY = smrc_pkg::POR_DELAY_CYC,
  parameter int MCD_TIMEOUT = smrc_pkg::MCD_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic supply_ok,
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  input wire logic irq_pending,
  input wire logic instr_done,
  input wire logic osc_clock_alive,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic core_reset,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic int_osc_en,
  output logic int_osc_select,
  output logic wdt_enable,
  output logic [3:0] wdt_clk_div_sel,
  output logic [7:0] port_latch,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic [15:0] pc_reset_value,
  output logic [7:0] stack_ptr_reset,
  output logic supply_mon_en,
  output logic irq
);

  // ========================================================================
  // Pin-side inputs pass two flip-flops before use.
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;

  // State, counters and software-visible registers.
  // Current sequencer state.
  smrc_pkg::smrc_state_t state_reg;
  // Cycles spent in the power-on release delay.
  logic [31:0] por_cnt_reg;
  // Cycles for which the oscillator has looked dead.
  logic [31:0] mcd_cnt_reg;
  // The six general purpose flags of the power control register.
  logic [5:0] gp_flags_reg;
  // Power-on cause flag, read through the cause register.
  logic por_flag_reg;
  // Supply monitor enable; only a power-on clears it.
  logic mon_en_reg;
  // Missing-clock detector enable; every reset clears it.
  logic mcd_en_reg;
  // Mode requests waiting for the writing instruction to finish.
  logic stop_pend_reg;
  logic idle_pend_reg;
  // One-cycle software reset request.
  logic swrst_reg;
  // Sticky interrupt status and its enable mask.
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_en_reg;

  // Data phase capture of the bus.
  // Kind of the transfer whose data phase is running.
  logic dp_write_reg;
  logic dp_read_reg;
  // Low byte of the address taken in the address phase.
  logic [7:0] dp_addr_reg;

  wire supply_ok_s = sync2_reg[0];
  wire ext_rst_s = sync2_reg[1];
  wire osc_alive_s = sync2_reg[2];

  // ========================================================================
  // Synchroniser for asynchronous pins.
  // The stages carry no reset: they only follow the pins, and a reset
  // value would hide the true pin level for two cycles after release.
  always_ff @(posedge ref_clk) begin
    sync1_reg <= {osc_clock_alive, ext_reset_req, supply_ok};
    sync2_reg <= sync1_reg;
  end

  // ========================================================================
  // Bus decode: writes are wait-free, reads take one wait state, and the
  // response is always OKAY.
  // An address phase counts only when the bus is ready and it is NONSEQ or SEQ.
  wire addr_ok = hsel && hready && htrans[1];
  // Write strobes live in the data phase, where hwdata stands; each one
  // is high for the single cycle that ends that phase.
  wire wr_pc = dp_write_reg && dp_addr_reg == smrc_pkg::PWR_CTRL_ADDR;
  wire wr_mon = dp_write_reg && dp_addr_reg == smrc_pkg::MON_CTRL_ADDR;
  wire wr_sw = dp_write_reg && dp_addr_reg == smrc_pkg::SWRST_ADDR;
  wire wr_ien = dp_write_reg && dp_addr_reg == smrc_pkg::IRQ_EN_ADDR;
  wire wr_iclr = dp_write_reg && dp_addr_reg == smrc_pkg::IRQ_CLR_ADDR;
  logic [31:0] rd_mux;

  // Read mux; command bits read zero, unmapped reads zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_addr_reg == smrc_pkg::PWR_CTRL_ADDR) begin
      rd_mux = {24'h00_0000, gp_flags_reg, 2'b00};
    end else if (dp_addr_reg == smrc_pkg::CAUSE_ADDR) begin
      rd_mux = {30'h0, por_flag_reg, 1'b0};
    end else if (dp_addr_reg == smrc_pkg::MON_CTRL_ADDR) begin
      rd_mux = {30'h0, mcd_en_reg, mon_en_reg};
    end else if (dp_addr_reg == smrc_pkg::IRQ_STAT_ADDR) begin
      rd_mux = {28'h000_0000, irq_stat_reg};
    end else if (dp_addr_reg == smrc_pkg::IRQ_EN_ADDR) begin
      rd_mux = {28'h000_0000, irq_en_reg};
    end
  end

  // Address phase is captured; a write's data phase completes next cycle.
  // Only the low address byte is kept; the register map fits in it.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dp_write_reg <= 1'b0;
      dp_read_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_write_reg <= addr_ok && hwrite;
      dp_read_reg <= addr_ok && !hwrite;
      if (addr_ok) begin
        dp_addr_reg <= haddr[7:0];
      end
    end
  end

  // Registered read data with one wait state. Ready drops for the first
  // data-phase cycle of a read, while the mux is loaded into hrdata, so
  // the data stands at the edge that ends the data phase. A write that
  // just finished has landed before the mux is sampled.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= dp_read_reg ? rd_mux : 32'h0000_0000;
      hreadyout <= !(addr_ok && !hwrite);
      hresp <= 1'b0;
    end
  end

  // ========================================================================
  // Reset classification. Monitor resets only count once enabled.
  // Watchdog requests come from logic on this clock and need no stages.
  wire mon_reset = mon_en_reg && !supply_ok_s;
  wire mcd_reset = mcd_en_reg && !osc_alive_s
                   && mcd_cnt_reg >= MCD_TIMEOUT;
  wire any_reset = ext_rst_s || wdt_reset_req || swrst_reg
                   || mcd_reset || mon_reset;
  // Mode select bits act as strobes; they are never stored as read data.
  wire pwr_wr_stop = wr_pc && hwdata[smrc_pkg::STOP_BIT];
  wire pwr_wr_idle = wr_pc && hwdata[smrc_pkg::IDLE_BIT];
  // True in any of the three reset states.
  wire in_reset = state_reg == smrc_pkg::SMRC_POR_HOLD
                  || state_reg == smrc_pkg::SMRC_POR_WAIT
                  || state_reg == smrc_pkg::SMRC_RESET;

  // Missing-clock timer: counts while the oscillator looks dead. It is
  // kept running in stop so a long stop trips it when software forgot.
  // The count saturates at the timeout, so it can never wrap to zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || osc_alive_s || !mcd_en_reg) begin
      mcd_cnt_reg <= 32'h0000_0000;
    end else if (mcd_cnt_reg < MCD_TIMEOUT) begin
      mcd_cnt_reg <= mcd_cnt_reg + 32'h0000_0001;
    end
  end

  // ========================================================================
  // Sequencer. rst_n acts as the power-on event.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= smrc_pkg::SMRC_POR_HOLD;
      por_cnt_reg <= 32'h0000_0000;
      stop_pend_reg <= 1'b0;
      idle_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        smrc_pkg::SMRC_POR_HOLD: begin
          // Wait here until the supply is above the reset threshold.
          por_cnt_reg <= 32'h0000_0000;
          if (supply_ok_s) begin
            state_reg <= smrc_pkg::SMRC_POR_WAIT;
          end
        end
        smrc_pkg::SMRC_POR_WAIT: begin
          // A supply that sags again restarts the whole wait.
          if (!supply_ok_s) begin
            state_reg <= smrc_pkg::SMRC_POR_HOLD;
          end else if (por_cnt_reg >= POR_DELAY - 1) begin
            state_reg <= smrc_pkg::SMRC_RUN;
          end else begin
            por_cnt_reg <= por_cnt_reg + 32'h0000_0001;
          end
        end
        smrc_pkg::SMRC_RESET: begin
          // Monitor resets have no release delay.
          if (!any_reset) begin
            state_reg <= smrc_pkg::SMRC_RUN;
          end
        end
        smrc_pkg::SMRC_RUN: begin
          // Reset beats a pending mode; stop is checked before idle so
          // that a write of both bits lands in stop.
          if (any_reset) begin
            state_reg <= smrc_pkg::SMRC_RESET;
          end else if (stop_pend_reg && instr_done) begin
            state_reg <= smrc_pkg::SMRC_STOP;
            stop_pend_reg <= 1'b0;
            idle_pend_reg <= 1'b0;
          end else if (idle_pend_reg && instr_done) begin
            state_reg <= smrc_pkg::SMRC_IDLE;
            idle_pend_reg <= 1'b0;
          end else begin
            stop_pend_reg <= stop_pend_reg || pwr_wr_stop;
            idle_pend_reg <= idle_pend_reg || pwr_wr_idle;
          end
        end
        smrc_pkg::SMRC_IDLE: begin
          // Peripherals keep running; a reset still takes priority.
          if (any_reset) begin
            state_reg <= smrc_pkg::SMRC_RESET;
          end else if (irq_pending) begin
            state_reg <= smrc_pkg::SMRC_RUN;
          end
        end
        smrc_pkg::SMRC_STOP: begin
          // Interrupts cannot wake stop; only a reset does.
          if (any_reset) begin
            state_reg <= smrc_pkg::SMRC_RESET;
          end
        end
        default: begin
          // An illegal code is treated as a reset, the safe side.
          state_reg <= smrc_pkg::SMRC_RESET;
        end
      endcase
    end
  end

  // ========================================================================
  // Software registers. Power control resets on any reset. The supply
  // monitor enable is cleared only by power-on.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gp_flags_reg <= smrc_pkg::PWR_CTRL_RESET[7:2];
      por_flag_reg <= 1'b0;
      mon_en_reg <= 1'b0;
      mcd_en_reg <= 1'b0;
      swrst_reg <= 1'b0;
    end else begin
      // The software reset request lasts one cycle; the sequencer takes
      // it in run, idle or stop alike.
      swrst_reg <= wr_sw && hwdata[0];
      if (state_reg == smrc_pkg::SMRC_POR_WAIT) begin
        por_flag_reg <= 1'b1;
      end else if (state_reg == smrc_pkg::SMRC_RESET) begin
        por_flag_reg <= 1'b0;
      end
      // Every reset returns the flags to zero; writes that arrive while
      // in reset are dropped.
      if (in_reset) begin
        gp_flags_reg <= smrc_pkg::PWR_CTRL_RESET[7:2];
        mcd_en_reg <= 1'b0;
      end else begin
        if (wr_pc) begin
          gp_flags_reg <= hwdata[7:smrc_pkg::FLAGS_LSB];
        end
        if (wr_mon) begin
          mcd_en_reg <= hwdata[1];
        end
      end
      // The supply monitor enable survives every reset but power-on.
      if (wr_mon && !in_reset) begin
        mon_en_reg <= hwdata[0];
      end
    end
  end

  // ========================================================================
  // Interrupt status: set wins over clear.
  // Events are levels taken from the state and mcd_reset, so a status bit
  // that software clears while the mode lasts stays set; the clear has no effect.
  wire [3:0] ev;
  assign ev[smrc_pkg::EV_STOP] = state_reg == smrc_pkg::SMRC_STOP;
  assign ev[smrc_pkg::EV_IDLE] = state_reg == smrc_pkg::SMRC_IDLE;
  assign ev[smrc_pkg::EV_WAKE] = state_reg == smrc_pkg::SMRC_IDLE
                                 && irq_pending;
  assign ev[smrc_pkg::EV_MCD] = mcd_reset;
  // Write-one-to-clear mask, present only in a clear write's data phase.
  wire [3:0] clr = wr_iclr ? hwdata[3:0] : 4'h0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_reg <= 4'h0;
      irq_en_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
      if (wr_ien) begin
        irq_en_reg <= hwdata[3:0];
      end
      // The output lags the status by one cycle so it comes from a flop.
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ========================================================================
  // Device-wide controls, all registered.
  // Seven of these are constants during and after reset; they are still
  // registered so that every pin of the block leaves a flip-flop.
  // Power-on and supply monitor resets are the ones that drive the pin;
  // external, watchdog, software and missing-clock resets leave it free.
  wire por_like = state_reg == smrc_pkg::SMRC_POR_HOLD
                  || state_reg == smrc_pkg::SMRC_POR_WAIT
                  || (state_reg == smrc_pkg::SMRC_RESET && mon_reset);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b1;
      core_reset <= 1'b1;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      int_osc_en <= 1'b1;
      int_osc_select <= 1'b1;
      wdt_enable <= 1'b0;
      wdt_clk_div_sel <= 4'h0;
      port_latch <= smrc_pkg::PORT_LATCH_RESET;
      port_open_drain <= 1'b1;
      weak_pullup_en <= 1'b1;
      pc_reset_value <= smrc_pkg::RESET_VECTOR;
      stack_ptr_reset <= smrc_pkg::STACK_PTR_RESET;
      supply_mon_en <= 1'b0;
    end else begin
      // The pin is open drain: it is only ever pulled low, and only while
      // a power-on or supply monitor reset holds the device.
      rst_pin_out <= 1'b0;
      rst_pin_oe <= por_like;
      core_reset <= in_reset;
      cpu_clk_en <= state_reg == smrc_pkg::SMRC_RUN;
      periph_clk_en <= state_reg != smrc_pkg::SMRC_STOP;
      int_osc_en <= state_reg != smrc_pkg::SMRC_STOP;
      int_osc_select <= 1'b1;
      wdt_enable <= !in_reset;
      wdt_clk_div_sel <= 4'(smrc_pkg::WDT_DIVIDE);
      port_latch <= smrc_pkg::PORT_LATCH_RESET;
      port_open_drain <= 1'b1;
      weak_pullup_en <= 1'b1;
      pc_reset_value <= smrc_pkg::RESET_VECTOR;
      stack_ptr_reset <= smrc_pkg::STACK_PTR_RESET;
      supply_mon_en <= mon_en_reg;
    end
  end

endmodule

// ---- tb/smrc_chk.sv ----
`timescale 1ns/1ps
// ==========================================
// Port checks for the mode and reset sequencer.
module smrc_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_reset_req,
  input wire logic irq_pending,
  input wire logic instr_done,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic core_reset,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic int_osc_en,
  input wire logic int_osc_select,
  input wire logic wdt_enable,
  input wire logic [3:0] wdt_clk_div_sel,
  input wire logic [7:0] port_latch,
  input wire logic port_open_drain,
  input wire logic weak_pullup_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Steps of the low-power modes.
  sequence stop_s;
    !int_osc_en;
  endsequence
  sequence idle_s;
    !cpu_clk_en && periph_clk_en && !core_reset;
  endsequence
  // Reads stall for one cycle only, and the slave never errors.
  a_bus_ready: assert property (
    !hreadyout |=> hreadyout) else $error("slave stalled");
  a_bus_okay: assert property (
    !hresp) else $error("error response");
  a_reset_entry: assert property (
    $rose(rst_n) |-> core_reset && rst_pin_oe) else $error("no reset");
  a_pin_drive: assert property (
    rst_pin_oe |-> !rst_pin_out && core_reset) else $error("pin drive");
  a_latch_safe: assert property (
    core_reset |-> port_latch == 8'hFF && port_open_drain &&
    weak_pullup_en) else $error("port latch state");
  a_exit_defaults: assert property (
    $fell(core_reset) |-> int_osc_select && wdt_enable &&
    wdt_clk_div_sel == 4'(smrc_pkg::WDT_DIVIDE)) else $error("exit defaults");
  a_stop_gates: assert property (
    stop_s |-> !cpu_clk_en && !periph_clk_en) else $error("stop gating");
  a_stop_exit: assert property (
    stop_s ##1 int_osc_en |-> core_reset) else $error("stop left");
  a_idle_wake: assert property (
    idle_s ##0 irq_pending |-> ##[1:4] cpu_clk_en) else $error("no wake");
  // The processor clock only stops after an instruction or by reset.
  a_entry_waits: assert property (
    $fell(cpu_clk_en) |-> core_reset || $past(instr_done) ||
    $past(instr_done, 2)) else $error("early mode entry");
  a_ext_reset: assert property (
    ext_reset_req [*2] |-> ##[0:5] core_reset) else $error("ext reset");
endmodule

bind smrc_top smrc_chk u_smrc_chk (.*);

// ---- tb/smrc_top_test.sv ----
`timescale 1ns/1ps
// ==========================================
// Register-level test of the mode and reset sequencer.
module smrc_top_test;
  logic ref_clk = 1'b0;
  logic rst_n, hsel, hwrite, hready, hreadyout, hresp, supply_ok;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ext_reset_req, wdt_reset_req, irq_pending, instr_done;
  logic osc_clock_alive, rst_pin_out, rst_pin_oe, core_reset, irq;
  logic cpu_clk_en, periph_clk_en, int_osc_en, int_osc_select;
  logic wdt_enable, port_open_drain, weak_pullup_en, supply_mon_en;
  logic [3:0] wdt_clk_div_sel;
  logic [7:0] port_latch, stack_ptr_reset;
  logic [15:0] pc_reset_value;
  int fails = 0;
  int n_compared = 0;
  int n;
  // The one slave's ready is the bus ready.
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;
  // Short delays keep the power-up wait within a few dozen cycles.
  smrc_top #(.POR_DELAY(20), .MCD_TIMEOUT(10)) u_smrc_top (.*);
  // ==========================================
  // Reporting.
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // Waits for core reset to reach v; n ends as the cycles spent.
  task automatic wait_core(input logic v, input int lim);
    n = 0;
    while (core_reset !== v) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > lim) begin
        fails++;
        give_verdict();
      end
    end
  endtask
  // ==========================================
  // One AHB-Lite single word transfer; read data lands in r.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    for (i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
        if (n > 50) begin
          fails++;
          give_verdict();
        end
      end while (hready !== 1'b1);
      if (i == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end else begin
        r = hrdata;
      end
    end
    // Read data is taken at the edge that ends the data phase; the step
    // after it lets outputs settle for what the caller checks next.
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  // One completed instruction, then time for the mode to settle.
  task automatic done();
    @(posedge ref_clk);
    instr_done <= 1'b1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // ==========================================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    {supply_ok, ext_reset_req, wdt_reset_req, irq_pending} = 4'h0;
    instr_done = 1'b0;
    osc_clock_alive = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk({core_reset, rst_pin_oe}, 2'h3);
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    wait_core(1'b0, 60);
    chk(n >= 20 && n <= 30, 1'b1);
    chk(rst_pin_oe, 1'b0);
    chk({int_osc_select, wdt_enable, wdt_clk_div_sel}, 6'h3C);
    chk({pc_reset_value, stack_ptr_reset}, 24'h000007);
    chk({port_latch, port_open_drain, weak_pullup_en}, 10'h3FF);
    chk(supply_mon_en, 1'b0);
    rd(smrc_pkg::CAUSE_ADDR, 32'h2, 32'h2);
    rd(smrc_pkg::PWR_CTRL_ADDR, 32'hFF, 32'h0);
    bus(1'b1, smrc_pkg::PWR_CTRL_ADDR, 32'hFC);
    rd(smrc_pkg::PWR_CTRL_ADDR, 32'hFF, 32'hFC);
    // Idle with its interrupt masked, then unmasked and cleared.
    bus(1'b1, smrc_pkg::IRQ_EN_ADDR, 32'h0);
    bus(1'b1, smrc_pkg::PWR_CTRL_ADDR, 32'hFD);
    rd(smrc_pkg::PWR_CTRL_ADDR, 32'hFF, 32'hFC);
    chk(cpu_clk_en, 1'b1);
    done();
    chk({cpu_clk_en, periph_clk_en, irq}, 3'h2);
    rd(smrc_pkg::IRQ_STAT_ADDR, 32'h2, 32'h2);
    bus(1'b1, smrc_pkg::IRQ_EN_ADDR, 32'h2);
    @(posedge ref_clk);
    irq_pending <= 1'b1;
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    #1;
    chk(irq, 1'b1);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(cpu_clk_en, 1'b1);
    rd(smrc_pkg::PWR_CTRL_ADDR, 32'hFF, 32'hFC);
    bus(1'b1, smrc_pkg::IRQ_CLR_ADDR, 32'h6);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(irq, 1'b0);
    rd(smrc_pkg::IRQ_STAT_ADDR, 32'h6, 32'h0);
    // An unmapped place ignores writes and reads zero.
    bus(1'b1, 8'h40, 32'hFF);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    // Stop, left by external, watchdog and missing-clock resets.
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, smrc_pkg::MON_CTRL_ADDR, (s == 2) ? 32'h3 : 32'h1);
      bus(1'b1, smrc_pkg::PWR_CTRL_ADDR, 32'hFF);
      chk(int_osc_en, 1'b1);
      done();
      chk({int_osc_en, cpu_clk_en, periph_clk_en}, 3'h0);
      repeat (30) @(posedge ref_clk);
      #1;
      chk(core_reset, 1'b0);
      @(posedge ref_clk);
      if (s == 0) ext_reset_req <= 1'b1;
      else if (s == 1) wdt_reset_req <= 1'b1;
      else osc_clock_alive <= 1'b0;
      wait_core(1'b1, 40);
      chk(rst_pin_oe, 1'b0);
      @(posedge ref_clk);
      {ext_reset_req, wdt_reset_req, osc_clock_alive} <= 3'h1;
      wait_core(1'b0, 60);
      rd(smrc_pkg::CAUSE_ADDR, 32'h2, 32'h0);
      rd(smrc_pkg::PWR_CTRL_ADDR, 32'hFF, 32'h0);
      chk(supply_mon_en, 1'b1);
    end
    // Supply dip with the monitor on, then a software reset.
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    wait_core(1'b1, 20);
    chk(rst_pin_oe, 1'b1);
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    wait_core(1'b0, 60);
    rd(smrc_pkg::CAUSE_ADDR, 32'h2, 32'h0);
    bus(1'b1, smrc_pkg::SWRST_ADDR, 32'h1);
    wait_core(1'b1, 20);
    wait_core(1'b0, 60);
    rd(smrc_pkg::MON_CTRL_ADDR, 32'h1, 32'h1);
    give_verdict();
  end
endmodule
